// [bus_controller_model.sv]
// Purpose: Controller stand-in, one command or event per cycle
// Assumes: Select changes just after the edge. Notes: one-hot, so codes never collide
`timescale 1ns/1ps
module bus_controller_model(
   input wire i_go,
   input wire [3:0] i_sel,
   output wire [15:0] o_ev);
   // One-hot event: bit i_sel of o_ev is set while i_go is high, else all bits are zero
   assign o_ev = i_go ? (16'h0001 << i_sel) : 16'h0000;
endmodule

// [command_error_reporter_test.sv]
// Purpose: Self-checking bench for the command error reporter
// Assumes: One clock; inputs driven 1 ns after the rising edge
// Notes: Expected codes and flags come from the rules, not from the design
`timescale 1ns/1ps
`include "error_reporter_defines.vh"
module command_error_reporter_test;
   reg i_clk, i_rst_b, go, flag, md;
   reg [3:0] sel, code;
   reg [15:0] val, vo, vl;
   reg [2:0] led;
   wire [15:0] ev;
   wire v, ae, se, pe, lg, lm, ls, sa, ca;
   wire [3:0] ac;
   integer err_count, cmp_count, seed, n;
   bus_controller_model i_ctl(.i_go(go), .i_sel(sel), .o_ev(ev));
   error_reporter i_dut(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bad_char(ev[0]), .i_bad_number(ev[1]),
      .i_bad_string(ev[2]), .i_syntax_error(ev[3]), .i_range_error(ev[4]), .i_talk_request(ev[7]),
      .i_query_pending(md), .i_slave_timeout(ev[9]), .i_cmd_voltage_setpoint(ev[5]),
      .i_cmd_current_setpoint(ev[5]), .i_cmd_voltage_soft_limit(ev[6]), .i_cmd_value(val),
      .i_cmd_current_soft_limit(ev[6]), .i_cmd_overvoltage_trip_set(ev[8]), .i_cmd_calibration(ev[10]),
      .i_error_query(ev[11]), .i_reset_cmd(ev[15]), .i_calibration_mode_select(md), .i_voltage_out(vo),
      .i_current_out(vo), .i_voltage_soft_limit(vl), .i_current_soft_limit(vl),
      .i_illegal_opcode_recovered(ev[12]), .i_master_restart(ev[13]), .i_slave_restart(ev[14]),
      .o_answer_valid(v), .o_answer_code(ac), .o_accum_err(ae), .o_status_err(se), .o_poll_err(pe),
      .o_setpoint_accept(sa), .o_calibration_accept(ca), .o_led_green(lg), .o_led_red_master(lm),
      .o_led_red_slave(ls));
   function [3:0] exp_code(input [3:0] s, input [15:0] value, input m);
      begin
         case (s)
            4'h0, 4'h1, 4'h2, 4'h3: exp_code = `ERR_CHAR;
            4'h4: exp_code = `ERR_RANGE;
            4'h5: exp_code = (value > vl) ? `ERR_SOFT_LIMIT : `ERR_NONE;
            4'h6: exp_code = (value < vo) ? `ERR_BAD_LIMIT : `ERR_NONE;
            4'h7: exp_code = m ? `ERR_NONE : `ERR_NO_QUERY;
            4'h8: exp_code = (value < vo) ? `ERR_OVP_LOW : `ERR_NONE;
            4'h9: exp_code = `ERR_SLAVE;
            4'hA: exp_code = m ? `ERR_NONE : `ERR_CAL;
            default: exp_code = `ERR_NONE;
         endcase
      end
   endfunction
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task step(input [3:0] s, input [15:0] value, input m);
      begin
         sel = s;
         val = value;
         md = m;
         @(posedge i_clk);
         #1;
         if (s == 11) chk({4'h0, ac}, {4'h0, code});
         if (exp_code(s, value, m) != `ERR_NONE) begin
            code = exp_code(s, value, m);
            flag = 1'b1;
         end else if (s == 11) begin
            code = 4'h0;
            flag = 1'b0;
         end
         if (s > 11) led = (s == 15) ? 3'b000 : led | (3'b001 << (s - 4'hC));
         chk({4'h0, v, ae, se, pe}, {4'h0, s == 11, {3{flag}}});
         chk({5'h00, ls, lm, lg}, {5'h00, led});
         chk({6'h00, sa, ca}, {6'h00, s == 5 && value <= vl, s == 10 && m});
      end
   endtask
   task results;
      begin
         $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      i_clk = 0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      #8000;
      err_count = err_count + 1;
      results;
   end
   initial begin
      seed = 23493;
      err_count = 0;
      cmp_count = 0;
      {code, flag, led, go, sel, md} = 14'h0000;
      {val, vo, vl, i_rst_b} = {16'h0000, 16'h0080, 16'h0100, 1'b0};
      repeat (2) @(posedge i_clk);
      #1;
      i_rst_b = 1;
      go = 1;
      step(11, 16'h0000, 1'b0);
      for (n = 0; n < 16; n = n + 1) step(n[3:0], (n == 5) ? 16'h0101 : 16'h007F, 1'b0);
      // Values on a limit are legal; an open mode lifts the query and calibration refusals
      step(5, 16'h0100, 1'b0);
      step(6, 16'h0080, 1'b0);
      step(8, 16'h0080, 1'b0);
      step(7, 16'h0000, 1'b1);
      step(10, 16'h0000, 1'b1);
      step(0, 16'h0000, 1'b0);
      step(11, 16'h0000, 1'b0);
      step(11, 16'h0000, 1'b0);
      repeat (400) begin
         n = $random(seed);
         step(n[3:0], 16'h0040 + {7'h00, n[13:5]}, n[4]);
      end
      // Reset in mid-run clears code, flags and indicators
      i_rst_b = 0;
      #1;
      chk({v, ae, se, pe, sa, ca, lg, lm}, 8'h00);
      chk({3'h0, ls, ac}, 8'h00);
      {code, flag, led} = 8'h00;
      @(posedge i_clk);
      #1;
      i_rst_b = 1;
      step(11, 16'h0000, 1'b0);
      step(3, 16'h0000, 1'b0);
      step(11, 16'h0000, 1'b0);
      go = 0;
      results;
   end
endmodule

// [error_reporter.v]
// Purpose: Error code capture, error flag and diagnostic indicators of a bus interface card
// Assumes: Parser delivers one-cycle event strobes; inputs synchronous to i_clk
// Notes: Error flag is mirrored in accumulated, live and serial poll status bits
//
// Summary of operation
// RULE1: Error query answers with pending error code; zero means no error pending.
// RULE2: Answering the error query clears the error flag.
// RULE3: Character outside command alphabet records code 4 and sets flag.
// RULE4: Numeric characters not forming a valid number record a parse error.
// RULE5: Unknown command or misplaced word, number, separator, terminator records parse error.
// RULE6: Parameter outside allowed range records code 5.
// RULE7: Setpoint above programmed soft limit is rejected with code 6.
// RULE8: Soft limit programmed below present output records code 7.
// RULE9: Talk request without prior query records code 8.
// RULE10: Overvoltage trip value below present output voltage records code 9.
// RULE11: Slave processor not responding records code 10.
// RULE12: Calibration command outside calibration mode is refused with code 12.
// RULE13: Reset command switches off all three diagnostic indicators. Here an indicator whose set event arrives in the same cycle stays lit.
// RULE14: Green indicator lights after recovery from an illegal operation code.
// RULE15: Illegal opcode recovery gives no indication on the bus.
// RULE16: First red indicator lights on master processor noise restart.
// RULE17: Second red indicator lights on slave processor noise restart.
// RULE18: Error query clears flag in accumulated, live and serial poll registers.
// RULE19: Pending code held until read; then zero until a new error.
`timescale 1ns/1ps
`include "error_reporter_defines.vh"

module error_reporter (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_b,
   // Parser events, one-cycle strobes
   input wire i_bad_char,
   input wire i_bad_number,
   input wire i_bad_string,
   input wire i_syntax_error,
   input wire i_range_error,
   input wire i_talk_request,
   input wire i_query_pending,
   input wire i_slave_timeout,
   // Decoded commands, one-cycle strobes with value
   input wire i_cmd_voltage_setpoint,
   input wire i_cmd_current_setpoint,
   input wire i_cmd_voltage_soft_limit,
   input wire i_cmd_current_soft_limit,
   input wire i_cmd_overvoltage_trip_set,
   input wire i_cmd_calibration,
   input wire [`VALUE_W-1:0] i_cmd_value,
   input wire i_error_query,
   input wire i_reset_cmd,
   // Present state of the supply
   input wire i_calibration_mode_select,
   input wire [`VALUE_W-1:0] i_voltage_out,
   input wire [`VALUE_W-1:0] i_current_out,
   input wire [`VALUE_W-1:0] i_voltage_soft_limit,
   input wire [`VALUE_W-1:0] i_current_soft_limit,
   // Processor watch events
   input wire i_illegal_opcode_recovered,
   input wire i_master_restart,
   input wire i_slave_restart,
   // Query answer
   output reg o_answer_valid,
   output reg [`ERR_CODE_W-1:0] o_answer_code,
   // Error flag copies
   output reg o_accum_err,
   output reg o_status_err,
   output reg o_poll_err,
   // Accepted setpoint and refusals
   output reg o_setpoint_accept,
   output reg o_calibration_accept,
   // Diagnostic indicators
   output reg o_led_green,
   output reg o_led_red_master,
   output reg o_led_red_slave
);

   // ******************************
   // Shared functions
   // ******************************
   // Strict compares for every limit check (exceeds here, falls_below below), so all checks agree on the boundary
   function exceeds;
      input [`VALUE_W-1:0] value;
      input [`VALUE_W-1:0] limit;
      begin
         exceeds = (value > limit);
      end
   endfunction

   function falls_below;
      input [`VALUE_W-1:0] value;
      input [`VALUE_W-1:0] level;
      begin
         falls_below = (value < level);
      end
   endfunction

   // Set beats clear in one cycle, so an event next to a reset command is never lost
   function led_next;
      input current;
      input set_event;
      input clear_cmd;
      begin
         led_next = set_event | (current & ~clear_cmd);
      end
   endfunction

   // ******************************
   // Event decode
   // ******************************
   wire parse_hit;
   wire range_hit;
   wire v_setpoint_hit;
   wire c_setpoint_hit;
   wire v_limit_hit;
   wire c_limit_hit;
   wire talk_hit;
   wire trip_hit;
   wire slave_hit;
   wire cal_hit;
   wire setpoint_cmd;

   // The four parse classes share one code
   assign parse_hit = i_bad_char | i_bad_number | // RULE3 RULE4
      i_bad_string | i_syntax_error; // RULE5
   assign range_hit = i_range_error; // RULE6
   // Limit checks are strict: a value equal to its limit is legal
   assign v_setpoint_hit = i_cmd_voltage_setpoint &
      exceeds(i_cmd_value, i_voltage_soft_limit); // RULE7
   assign c_setpoint_hit = i_cmd_current_setpoint &
      exceeds(i_cmd_value, i_current_soft_limit); // RULE7
   assign v_limit_hit = i_cmd_voltage_soft_limit &
      falls_below(i_cmd_value, i_voltage_out); // RULE8
   assign c_limit_hit = i_cmd_current_soft_limit &
      falls_below(i_cmd_value, i_current_out); // RULE8
   assign talk_hit = i_talk_request & ~i_query_pending; // RULE9
   assign trip_hit = i_cmd_overvoltage_trip_set &
      falls_below(i_cmd_value, i_voltage_out); // RULE10
   assign slave_hit = i_slave_timeout; // RULE11
   assign cal_hit = i_cmd_calibration & ~i_calibration_mode_select; // RULE12
   assign setpoint_cmd = i_cmd_voltage_setpoint | i_cmd_current_setpoint;

   // ******************************
   // Error classification
   // ******************************
   reg [`ERR_CODE_W-1:0] event_code;
   reg event_hit;

   // Syntax classes first, since a malformed command has no value to check
   always @* begin
      event_hit = 1'b1;
      event_code = `ERR_NONE;
      if (parse_hit) begin
         event_code = `ERR_CHAR; // RULE3 RULE4 RULE5
      end else if (range_hit) begin
         event_code = `ERR_RANGE; // RULE6
      end else if (v_setpoint_hit | c_setpoint_hit) begin
         event_code = `ERR_SOFT_LIMIT; // RULE7
      end else if (v_limit_hit | c_limit_hit) begin
         event_code = `ERR_BAD_LIMIT; // RULE8
      end else if (talk_hit) begin
         event_code = `ERR_NO_QUERY; // RULE9
      end else if (trip_hit) begin
         event_code = `ERR_OVP_LOW; // RULE10
      end else if (slave_hit) begin
         event_code = `ERR_SLAVE; // RULE11
      end else if (cal_hit) begin
         event_code = `ERR_CAL; // RULE12
      end else begin
         event_hit = 1'b0;
      end
   end

   // ******************************
   // Pending error
   // ******************************
   reg [`ERR_CODE_W-1:0] pending_code;
   reg err_flag;
   reg [`ERR_CODE_W-1:0] next_code;
   reg next_flag;

   // New event wins over a query clear in the same cycle
   // Only the newest error is kept; an unread older code is overwritten
   always @* begin
      next_code = pending_code;
      next_flag = err_flag;
      if (i_error_query) begin
         next_code = `ERR_NONE; // RULE19
         next_flag = 1'b0; // RULE2
      end
      if (event_hit) begin
         next_code = event_code; // RULE19
         next_flag = 1'b1;
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pending_code <= `ERR_NONE;
      end else begin
         pending_code <= next_code; // RULE19
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         err_flag <= 1'b0;
      end else begin
         err_flag <= next_flag; // RULE2
      end
   end

   // ******************************
   // Query answer
   // ******************************
   reg next_answer_valid;
   reg [`ERR_CODE_W-1:0] next_answer_code;

   // Answer carries the code pending before this query
   always @* begin
      next_answer_valid = i_error_query; // RULE1
      next_answer_code = o_answer_code;
      if (i_error_query) begin
         next_answer_code = pending_code; // RULE1
      end
   end

   // Code holds between queries so a slow reader still sees it
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_answer_valid <= 1'b0;
      end else begin
         o_answer_valid <= next_answer_valid; // RULE1
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_answer_code <= `ERR_NONE;
      end else begin
         o_answer_code <= next_answer_code; // RULE1
      end
   end

   // ******************************
   // Status flag copies
   // ******************************
   // One flag, seen by three status registers
   // Three flops rather than one fan-out, so each copy meets timing at its own reader
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_accum_err <= 1'b0;
      end else begin
         o_accum_err <= next_flag; // RULE18
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_status_err <= 1'b0;
      end else begin
         o_status_err <= next_flag; // RULE18
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_poll_err <= 1'b0;
      end else begin
         o_poll_err <= next_flag; // RULE18
      end
   end

   // ******************************
   // Command acceptance
   // ******************************
   reg next_setpoint_accept;
   reg next_calibration_accept;

   // A command is accepted only in a cycle with no error of any class
   always @* begin
      next_setpoint_accept = setpoint_cmd & ~event_hit; // RULE7
      next_calibration_accept = i_cmd_calibration & ~event_hit; // RULE12
   end

   // Accept strobes last one cycle, like the command strobes
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_setpoint_accept <= 1'b0;
      end else begin
         o_setpoint_accept <= next_setpoint_accept; // RULE7
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_calibration_accept <= 1'b0;
      end else begin
         o_calibration_accept <= next_calibration_accept; // RULE12
      end
   end

   // ******************************
   // Diagnostic indicators
   // ******************************
   reg next_led_green;
   reg next_led_red_master;
   reg next_led_red_slave;

   // Opcode recovery only lights an indicator; nothing reaches the error path or the bus
   always @* begin
      next_led_green = led_next(o_led_green, i_illegal_opcode_recovered, // RULE14 RULE15
         i_reset_cmd); // RULE13
      next_led_red_master = led_next(o_led_red_master, i_master_restart, // RULE16
         i_reset_cmd); // RULE13
      next_led_red_slave = led_next(o_led_red_slave, i_slave_restart, // RULE17
         i_reset_cmd); // RULE13
   end

   // Only the reset command or the reset pin turns an indicator off
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_led_green <= 1'b0;
      end else begin
         o_led_green <= next_led_green; // RULE14
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_led_red_master <= 1'b0;
      end else begin
         o_led_red_master <= next_led_red_master; // RULE16
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_led_red_slave <= 1'b0;
      end else begin
         o_led_red_slave <= next_led_red_slave; // RULE17
      end
   end

endmodule

// [error_reporter_checker.sv]
// Purpose: Port checker for the error reporter
// Assumes: One clock domain. Notes: bound to every instance
`timescale 1ns/1ps
`include "error_reporter_defines.vh"
module error_reporter_checker(
   input wire i_clk, i_rst_b, i_bad_char, i_error_query, i_reset_cmd, i_master_restart,
   input wire i_illegal_opcode_recovered, i_slave_restart, i_cmd_calibration,
   input wire i_calibration_mode_select, o_calibration_accept, o_answer_valid, o_accum_err,
   input wire o_status_err, o_poll_err, o_led_green, o_led_red_master, o_led_red_slave,
   input wire [`ERR_CODE_W-1:0] o_answer_code);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   ans_pulse_a: assert property (i_error_query |=> o_answer_valid) else $error("no answer");
   flag_copy_a: assert property (o_status_err == o_accum_err && o_poll_err == o_accum_err)
      else $error("flag copies differ");
   char_flag_a: assert property (i_bad_char |=> o_accum_err) else $error("no flag");
   char_code_a: assert property (i_bad_char ##1 i_error_query |=> o_answer_code == `ERR_CHAR)
      else $error("wrong code");
   cal_refuse_a: assert property (i_cmd_calibration && !i_calibration_mode_select
      |=> !o_calibration_accept) else $error("calibration taken");
   green_led_a: assert property (i_illegal_opcode_recovered |=> o_led_green) else $error("green");
   red_master_a: assert property (i_master_restart |=> o_led_red_master) else $error("red");
   red_slave_a: assert property (i_slave_restart |=> o_led_red_slave) else $error("red two");
   led_off_a: assert property (i_reset_cmd && !(i_illegal_opcode_recovered | i_master_restart |
      i_slave_restart) |=> !(o_led_green | o_led_red_master | o_led_red_slave)) else $error("leds");
   cover property (i_bad_char ##1 i_error_query);
   cover property (i_reset_cmd ##1 !o_led_green);
   cover property (i_slave_restart ##1 o_led_red_slave);
endmodule
bind error_reporter error_reporter_checker i_chk(.*);

// [error_reporter_defines.vh]
// Purpose: Constants for the command error reporter
// Assumes: Included by error_reporter.v
// Notes: Codes and widths as used by the command parser interface
`ifndef ERROR_REPORTER_DEFINES_VH
`define ERROR_REPORTER_DEFINES_VH
`define ERR_CODE_W 4
`define ERR_NONE 4'h0
`define ERR_CHAR 4'h4
`define ERR_RANGE 4'h5
`define ERR_SOFT_LIMIT 4'h6
`define ERR_BAD_LIMIT 4'h7
`define ERR_NO_QUERY 4'h8
`define ERR_OVP_LOW 4'h9
`define ERR_SLAVE 4'hA
`define ERR_CAL 4'hC
`define VALUE_W 16
`define STATUS_W 13
`define STATUS_ERR_BIT 7
`endif
